// ==== rtl/fid_bus_port.sv ====
`timescale 1ns/10ps
module fid_bus_port
    import fid_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // avalon-mm slave side
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    output logic             avs_waitrequest,
    output logic [31:0]      avs_readdata,
    output logic [1:0]       avs_response,
    // register decode side
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_hit,
    input  wire logic        wr_hit,
    output logic             wr_commit
);

    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  resp_reg;
    logic        req;
    logic        hit;

    // ----------------------------------------------------------------
    // one wait cycle, then accept
    // ----------------------------------------------------------------
    assign req             = avs_read | avs_write;
    assign hit             = avs_read ? rd_hit : wr_hit;
    assign avs_waitrequest = req & ~ack_reg;
    // write lands on the edge where waitrequest is seen low
    assign wr_commit       = avs_write & ack_reg;
    assign avs_readdata    = rdata_reg;
    assign avs_response    = resp_reg;

    // ack toggles so back-to-back requests each get a wait cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_reg   <= 1'b0;
            rdata_reg <= WORD_ZERO;
            resp_reg  <= RESP_OKAY;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (req & ~ack_reg) begin
                rdata_reg <= avs_read ? rd_data : WORD_ZERO;
                resp_reg  <= hit ? RESP_OKAY : RESP_DECERR;
            end
        end
    end

endmodule

// ==== rtl/fid_pkg.sv ====
package fid_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_FEATURE_ID_WORD_3 = 8'h0C;
    localparam logic [7:0] OFS_FEATURE_ID_WORD_4 = 8'h10;
    localparam logic [7:0] OFS_FEATURE_ID_WORD_5 = 8'h14;
    localparam logic [7:0] OFS_STREAM_CFG        = 8'h20;
    localparam logic [7:0] OFS_STALL_STATUS      = 8'h24;

    // ----------------------------------------------------------------
    // word 3 field positions
    // ----------------------------------------------------------------
    localparam int POS_WALK_NC      = 14;
    localparam int POS_USER_FAULT   = 13;
    localparam int POS_BRK_LO       = 11;
    localparam int POS_RANGE_INV    = 10;
    localparam int POS_SMALL_TABLE  = 9;
    localparam int POS_S2_ATTR      = 8;
    localparam int POS_PARTITION    = 7;
    localparam int POS_PASID_OVF    = 5;
    localparam int POS_SPLIT_XN     = 4;
    localparam int POS_PAGE_HW_ATTR = 3;
    localparam int POS_HIER_DIS     = 2;

    // ----------------------------------------------------------------
    // word 5 field positions
    // ----------------------------------------------------------------
    localparam int POS_STALL_MAX_LO = 16;
    localparam int POS_IAX_LO       = 10;
    localparam int POS_WIDE_DESC    = 8;
    localparam int POS_SMALL_52     = 7;
    localparam int POS_GRAN_64K     = 6;
    localparam int POS_GRAN_16K     = 5;
    localparam int POS_GRAN_4K      = 4;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] IAX_48          = 2'h0;
    localparam logic [1:0] IAX_52          = 2'h1;
    localparam logic [1:0] IAX_56          = 2'h2;
    localparam logic [1:0] BRK_LEVEL_0     = 2'h0;
    localparam logic [1:0] BRK_LEVEL_1     = 2'h1;
    localparam logic [1:0] BRK_LEVEL_2     = 2'h2;
    localparam logic [1:0] FIELD_A_NOSTALL = 2'h1;
    localparam logic [2:0] REV_0           = 3'h0;
    localparam logic [2:0] REV_2           = 3'h2;
    localparam logic [2:0] REV_3           = 3'h3;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_DECERR     = 2'h3;
    localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

    // ----------------------------------------------------------------
    // software stream configuration, reset value zero
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] part_id;
        logic       hier_disable_bit_hi;
        logic       hier_disable_bit_lo;
        logic       forced_write_back_bit;
        logic       pasid_on_response_bit;
        logic       stage2_walk_protect_bit;
    } fid_cfg_t;
    localparam int       CFG_W     = 13;
    localparam fid_cfg_t CFG_RESET = '0;

    // effective behaviour handed to the translation datapath
    typedef struct packed {
        logic [7:0] part_id;
        logic       had_hi_on;
        logic       had_lo_on;
        logic       s2wb_on;
        logic       pasid_ovf;
        logic       walk_normal_nc;
        logic       user_exec_ok;
        logic       kernel_exec_ok;
    } fid_eff_t;
    localparam fid_eff_t EFF_RESET = '0;

    // one bus request as seen by the register decode
    typedef struct packed {
        logic [7:0]  addr;
        logic [3:0]  byteenable;
        logic [31:0] wdata;
    } fid_req_t;

endpackage

// ==== rtl/fid_regs.sv ====
// What this block does
// R1 - walk flag set and no walk protect: device-type stage-1 walks become normal non-cacheable
// R2 - bit 13 reports the user fault-on-access mechanism
// R3 - bits 12:11 give break-before-make level; later revisions report level 1 or 2
// R4 - bit 10 reports range invalidation with level hints
// R5 - bit 9 reports small tables; forced on with secure stage 2
// R6 - bit 8 reports stage-2 attribute control; else forced write-back bit reads zero
// R7 - bit 7 reports partitioning; when clear its fields read zero
// R8 - bit 5 forces PASID on overflow responses; else the entry bit decides
// R9 - bit 4 splits execute-never into user and kernel permissions
// R10 - bit 3 reports page hardware attributes and then forces hierarchical disable
// R11 - bit 2 makes hierarchical disable bits effective; zero without stage 1
// R12 - identification words at 0x0C, 0x10, 0x14 are read only
// R13 - fourth word carries a free implementation value
// R14 - bits 31:16 limit outstanding stall records; zero when stalling disabled
// R15 - bits 11:10 encode input address size 48, 52 or 56 bits
// R16 - extended input addresses need a fitting granule; 56 bits needs wide descriptors
// R17 - wide descriptors force 56-bit inputs and drop 32-bit long tables
// R18 - bit 7 means 52-bit small granules; zero without 4KB or 16KB
// R19 - bits 6, 5, 4 report 64KB, 16KB, 4KB granules
// R20 - writes to identification words ignored; reserved bits read zero
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module fid_regs
    import fid_pkg::*;
#(
    parameter logic [2:0]  ARCH_REV    = 3'h4,
    parameter bit          STAGE1      = 1'b1,
    parameter bit          STAGE2      = 1'b1,
    parameter bit          PAGE_REQ    = 1'b1,
    parameter bit          SUBSTREAMS  = 1'b1,
    parameter bit          SECURE_S2   = 1'b0,
    parameter bit          HAS_WALK_NC = 1'b1,
    parameter bit          HAS_E0      = 1'b1,
    parameter logic [1:0]  BRK_LEVEL   = 2'h1,
    parameter bit          RANGE_INV   = 1'b1,
    parameter bit          SMALL_TBL   = 1'b0,
    parameter bit          S2_ATTR     = 1'b1,
    parameter bit          HAS_PART    = 1'b0,
    parameter bit          PASID_OVF   = 1'b0,
    parameter bit          SPLIT_XN    = 1'b1,
    parameter bit          PAGE_ATTR   = 1'b0,
    parameter bit          HAS_HAD     = 1'b1,
    // arbitrary value, no meaning beyond this design
    parameter logic [31:0] IMPL_WORD   = 32'h0000_0000,
    parameter logic [15:0] STALL_MAX   = 16'h0010,
    parameter logic [1:0]  FIELD_A     = 2'h0,
    parameter logic [1:0]  IN_ADDR_EXT = 2'h1,
    parameter bit          WIDE_DESC   = 1'b0,
    parameter bit          SMALL_52    = 1'b0,
    parameter bit          G64K        = 1'b1,
    parameter bit          G16K        = 1'b0,
    parameter bit          G4K         = 1'b1,
    parameter bit          LONG32      = 1'b0
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic             avs_waitrequest,
    output logic [31:0]      avs_readdata,
    output logic [1:0]       avs_response,
    // translation datapath inputs
    input  wire logic        walk_device_in,
    input  wire logic [1:0]  execute_never_field,
    // stall record events
    input  wire logic        stall_rec_req,
    input  wire logic        stall_rec_done,
    output logic             stall_rec_accept,
    // effective behaviour
    output fid_eff_t         eff_out,
    output logic             split_xn_active
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    fid_req_t    req;
    fid_cfg_t    cfg_reg;
    fid_cfg_t    cfg_next;
    fid_cfg_t    cfg_wr;
    fid_eff_t    eff_reg;
    fid_eff_t    eff_next;
    logic [31:0] word3;
    logic [31:0] word4;
    logic [31:0] word5;
    logic [31:0] cfg_word;
    logic [31:0] stat_word;
    logic [31:0] rd_data;
    logic [31:0] be_mask;
    logic [31:0] cfg_merged;
    logic        rd_hit;
    logic        wr_hit;
    logic        wr_commit;
    logic        sel_w3;
    logic        sel_w4;
    logic        sel_w5;
    logic        sel_cfg;
    logic        sel_stat;
    logic [15:0] stall_count;
    logic        walk_nc_flag;
    logic        user_fault_flag;
    logic [1:0]  break_make_level;
    logic        range_invalidate_flag;
    logic        small_table_flag;
    logic        stage2_attr_control_flag;
    logic        partition_flag;
    logic        pasid_on_overflow_response_flag;
    logic        split_execute_never_flag;
    logic        page_hw_attr_flag;
    logic        hier_disable_flag;
    logic [15:0] stall_limit;
    logic [1:0]  input_address_extend;
    logic        wide_descriptor_flag;
    logic        small_granule_52bit_flag;
    logic        granule_64k_flag;
    logic        granule_16k_flag;
    logic        granule_4k_flag;
    logic        small_gran_ok;
    logic        iax_req_ok;
    logic        s52_raw;
    logic        rev_later;

    // ----------------------------------------------------------------
    // word 3 feature derivation
    // ----------------------------------------------------------------
    assign rev_later = (ARCH_REV != REV_0);
    // R1 walk flag
    assign walk_nc_flag = STAGE2 & (HAS_WALK_NC | (ARCH_REV >= REV_3));
    // R2 fault flag
    assign user_fault_flag = HAS_E0 | (ARCH_REV >= REV_3);
    // R3 level clamp: reserved code falls to level 2, later revs at least 1
    assign break_make_level = (BRK_LEVEL > BRK_LEVEL_2) ? BRK_LEVEL_2 :
                              ((ARCH_REV >= REV_2) && (BRK_LEVEL == BRK_LEVEL_0)) ? BRK_LEVEL_1 :
                              BRK_LEVEL;
    // R4 range invalidation
    assign range_invalidate_flag = RANGE_INV | (ARCH_REV >= REV_2);
    // R5 small tables
    assign small_table_flag = SMALL_TBL | SECURE_S2;
    // R6 attribute control
    assign stage2_attr_control_flag = S2_ATTR | (ARCH_REV >= REV_2);
    // R7 partitioning
    assign partition_flag = HAS_PART;
    // R8 overflow pasid
    assign pasid_on_overflow_response_flag = PASID_OVF & PAGE_REQ & SUBSTREAMS;
    // R9 mandatory with stage 2 after first revision
    assign split_execute_never_flag = STAGE2 & rev_later;
    // R10 page attributes need stage 1 so the disable bit can follow
    assign page_hw_attr_flag = PAGE_ATTR & rev_later & STAGE1;
    // R11 hierarchical disable
    assign hier_disable_flag = STAGE1 & (HAS_HAD | rev_later | page_hw_attr_flag);

    // ----------------------------------------------------------------
    // word 5 feature derivation
    // ----------------------------------------------------------------
    // R14 limit gone when stalling is not possible
    assign stall_limit = (FIELD_A == FIELD_A_NOSTALL) ? 16'h0000 : STALL_MAX;
    // R19 4KB forced with 32-bit long tables; R17 those go with wide descriptors
    assign granule_4k_flag  = G4K | (LONG32 & ~WIDE_DESC);
    assign granule_16k_flag = G16K;
    assign granule_64k_flag = G64K;
    // R18 small granule flag needs 4KB or 16KB
    assign s52_raw       = SMALL_52 & (granule_4k_flag | granule_16k_flag) & rev_later;
    // R16 extended inputs need a usable granule
    assign small_gran_ok = granule_64k_flag | s52_raw;
    assign iax_req_ok    = rev_later & small_gran_ok;
    // R17 wide descriptors only when 56 bits is reachable
    assign wide_descriptor_flag = WIDE_DESC & iax_req_ok;
    // R15 encoding, first revision falls back to 48, reserved codes to 52 with small granules else 48
    assign input_address_extend =
        ~iax_req_ok                 ? IAX_48 :
        wide_descriptor_flag        ? IAX_56 :
        (IN_ADDR_EXT == IAX_56)     ? IAX_52 :
        (IN_ADDR_EXT == IAX_52)     ? IAX_52 :
        s52_raw                     ? IAX_52 : IAX_48;
    // R18 dropped unless inputs reach 52 bits
    assign small_granule_52bit_flag = s52_raw & (input_address_extend != IAX_48);

    // ----------------------------------------------------------------
    // word assembly, unnamed bits stay zero
    // ----------------------------------------------------------------
    // R20 reserved bits
    always_comb begin
        word3 = WORD_ZERO;
        word5 = WORD_ZERO;
        word3[POS_WALK_NC]                 = walk_nc_flag;
        word3[POS_USER_FAULT]              = user_fault_flag;
        word3[POS_BRK_LO+1:POS_BRK_LO]     = break_make_level;
        word3[POS_RANGE_INV]               = range_invalidate_flag;
        word3[POS_SMALL_TABLE]             = small_table_flag;
        word3[POS_S2_ATTR]                 = stage2_attr_control_flag;
        word3[POS_PARTITION]               = partition_flag;
        word3[POS_PASID_OVF]               = pasid_on_overflow_response_flag;
        word3[POS_SPLIT_XN]                = split_execute_never_flag;
        word3[POS_PAGE_HW_ATTR]            = page_hw_attr_flag;
        word3[POS_HIER_DIS]                = hier_disable_flag;
        word5[POS_STALL_MAX_LO+15:POS_STALL_MAX_LO] = stall_limit;
        word5[POS_IAX_LO+1:POS_IAX_LO]     = input_address_extend;
        word5[POS_WIDE_DESC]               = wide_descriptor_flag;
        word5[POS_SMALL_52]                = small_granule_52bit_flag;
        word5[POS_GRAN_64K]                = granule_64k_flag;
        word5[POS_GRAN_16K]                = granule_16k_flag;
        word5[POS_GRAN_4K]                 = granule_4k_flag;
    end

    // R13 free value
    assign word4 = IMPL_WORD;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    assign req.addr       = avs_address;
    assign req.byteenable = avs_byteenable;
    assign req.wdata      = avs_writedata;

    assign sel_w3   = (req.addr == OFS_FEATURE_ID_WORD_3);
    assign sel_w4   = (req.addr == OFS_FEATURE_ID_WORD_4);
    assign sel_w5   = (req.addr == OFS_FEATURE_ID_WORD_5);
    assign sel_cfg  = (req.addr == OFS_STREAM_CFG);
    assign sel_stat = (req.addr == OFS_STALL_STATUS);

    assign rd_hit = sel_w3 | sel_w4 | sel_w5 | sel_cfg | sel_stat;
    // R12 identification words accept writes but store nothing
    assign wr_hit = rd_hit;

    assign cfg_word  = {{(32-CFG_W){1'b0}}, cfg_reg};
    assign stat_word = {16'h0000, stall_count};

    // read mux, unmapped reads zero
    assign rd_data = sel_w3   ? word3 :
                     sel_w4   ? word4 :
                     sel_w5   ? word5 :
                     sel_cfg  ? cfg_word :
                     sel_stat ? stat_word : WORD_ZERO;

    // ----------------------------------------------------------------
    // stream configuration write with byte lanes
    // ----------------------------------------------------------------
    assign be_mask    = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
                         {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
    assign cfg_merged = (req.wdata & be_mask) | (cfg_word & ~be_mask);
    assign cfg_wr     = fid_cfg_t'(cfg_merged[CFG_W-1:0]);

    // unsupported fields are masked so they read back zero
    always_comb begin
        cfg_next = cfg_reg;
        if (wr_commit && sel_cfg) begin
            cfg_next = cfg_wr;
        end
        // R6 write-back bit tied off
        if (!stage2_attr_control_flag) begin
            cfg_next.forced_write_back_bit = 1'b0;
        end
        // R7 partition id tied off
        if (!partition_flag) begin
            cfg_next.part_id = 8'h00;
        end
        // R11 disable bits have no store without the feature
        if (!hier_disable_flag) begin
            cfg_next.hier_disable_bit_lo = 1'b0;
            cfg_next.hier_disable_bit_hi = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_reg <= CFG_RESET;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // ----------------------------------------------------------------
    // effective behaviour, registered so eff_out comes from flops
    // ----------------------------------------------------------------
    always_comb begin
        eff_next = EFF_RESET;
        // R1 device walks downgraded
        eff_next.walk_normal_nc = walk_device_in & walk_nc_flag &
                                  ~cfg_reg.stage2_walk_protect_bit;
        // R8 flag overrides the entry bit
        eff_next.pasid_ovf = pasid_on_overflow_response_flag |
                             cfg_reg.pasid_on_response_bit;
        // R6 write-back only with support
        eff_next.s2wb_on   = stage2_attr_control_flag & cfg_reg.forced_write_back_bit;
        // R11 disables only with support
        eff_next.had_lo_on = hier_disable_flag & cfg_reg.hier_disable_bit_lo;
        eff_next.had_hi_on = hier_disable_flag & cfg_reg.hier_disable_bit_hi;
        eff_next.part_id   = cfg_reg.part_id;
        // R9 two-bit form: 00 all, 01 user only, 10 none, 11 kernel only
        if (split_execute_never_flag) begin
            eff_next.user_exec_ok   = ~execute_never_field[1];
            eff_next.kernel_exec_ok = (execute_never_field == 2'h0) |
                                      (execute_never_field == 2'h3);
            if (execute_never_field == 2'h1) begin
                eff_next.user_exec_ok = 1'b1;
            end
            if (execute_never_field == 2'h3) begin
                eff_next.user_exec_ok = 1'b0;
            end
        end else begin
            // single bit form, low bit ignored
            eff_next.user_exec_ok   = ~execute_never_field[1];
            eff_next.kernel_exec_ok = ~execute_never_field[1];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            eff_reg <= EFF_RESET;
        end else begin
            eff_reg <= eff_next;
        end
    end

    assign eff_out         = eff_reg;
    assign split_xn_active = split_execute_never_flag;

    // ----------------------------------------------------------------
    // bus front end and stall tracking
    // ----------------------------------------------------------------
    fid_bus_port u_bus (
        .clk_sys         (clk_sys),
        .rst             (rst),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_waitrequest (avs_waitrequest),
        .avs_readdata    (avs_readdata),
        .avs_response    (avs_response),
        .rd_data         (rd_data),
        .rd_hit          (rd_hit),
        .wr_hit          (wr_hit),
        .wr_commit       (wr_commit)
    );

    // R14 records held under the limit
    fid_stall_track #(
        .CW (16)
    ) u_stall (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .limit      (stall_limit),
        .rec_req    (stall_rec_req),
        .rec_done   (stall_rec_done),
        .rec_accept (stall_rec_accept),
        .count      (stall_count)
    );

endmodule

// ==== rtl/fid_stall_track.sv ====
`timescale 1ns/10ps
module fid_stall_track #(
    parameter int CW = 16
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rst,
    // limit and events
    input  wire logic [CW-1:0] limit,
    input  wire logic          rec_req,
    input  wire logic          rec_done,
    output logic               rec_accept,
    output logic [CW-1:0]      count
);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic          dec;

    // ----------------------------------------------------------------
    // outstanding record count
    // ----------------------------------------------------------------
    // a new record is refused once the limit is reached
    assign rec_accept = rec_req & (count_reg < limit);
    // a resolve with nothing outstanding is dropped, never wraps
    assign dec        = rec_done & (count_reg != '0);
    assign count      = count_reg;

    // accept and resolve in one cycle cancel
    always_comb begin
        count_next = count_reg;
        if (rec_accept & ~dec) begin
            count_next = count_reg + CW'(1);
        end else if (dec & ~rec_accept) begin
            count_next = count_reg - CW'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule

// ==== tb/fid_regs_chk.sv ====
`timescale 1ns/10ps
module fid_regs_chk
    import fid_pkg::*;
(
    // clock, reset and bus
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic [1:0]  avs_response,
    // datapath
    input wire logic [1:0]  execute_never_field,
    input wire logic        split_xn_active,
    input wire fid_eff_t    eff_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // decoded places; anything else must answer as unmapped
    wire hit = avs_address inside {8'h0C, 8'h10, 8'h14, 8'h20, 8'h24};
    wire req = avs_read | avs_write;
    sequence s_done; req && !avs_waitrequest; endsequence
    sequence s_rd(a); avs_read && !avs_waitrequest && avs_address == a; endsequence
    a_wait_first: assert property ($rose(req) |-> avs_waitrequest) else $error("no wait");
    a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("late");
    a_id3_rsvd: assert property (s_rd(8'h0C) |-> avs_readdata[6] == 1'b0
        && avs_readdata[1:0] == 2'h0) else $error("word 3 reserved bits");
    a_id5_rsvd: assert property (s_rd(8'h14) |-> avs_readdata[15:12] == 4'h0
        && !avs_readdata[9] && !avs_readdata[3]) else $error("word 5 reserved bits");
    a_unmapped: assert property (s_done ##0 !hit |-> avs_response == 2'h3
        && avs_readdata == 32'h0) else $error("unmapped answer");
    a_mapped_ok: assert property (s_done ##0 hit |-> avs_response == 2'h0) else $error("resp");
    a_xn_user: assert property (split_xn_active && !$past(rst) |-> eff_out.user_exec_ok
        == !$past(execute_never_field[1])) else $error("user exec");
    a_xn_kernel: assert property (split_xn_active && !$past(rst) |-> eff_out.kernel_exec_ok
        == ($past(execute_never_field) inside {2'h0, 2'h3})) else $error("kernel exec");
endmodule
bind fid_regs fid_regs_chk u_chk (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
    .avs_waitrequest, .avs_readdata, .avs_response, .execute_never_field, .split_xn_active,
    .eff_out);

// ==== tb/tb_fid_regs.sv ====
`timescale 1ns/10ps
module tb_fid_regs;
    import fid_pkg::*;
    logic        clk_sys = 0, rst = 1, avs_read = 0, avs_write = 0, walk_device_in = 0;
    logic        stall_rec_req = 0, stall_rec_done = 0, avs_waitrequest, stall_rec_accept;
    logic        split_xn_active;
    logic [7:0]  avs_address = 8'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, lfsr = 32'd61315;
    logic [1:0]  execute_never_field = 2'h0, avs_response;
    logic [33:0] expq[$];
    logic [31:0] idw[3] = '{32'h0000_6D14, 32'h0, 32'h0010_0450};
    fid_eff_t    eff_out;
    int          fail_count = 0, n_compared = 0, cyc = 0;
    always #50 clk_sys = ~clk_sys;
    fid_regs DUT (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_waitrequest, .avs_readdata, .avs_response, .walk_device_in,
        .execute_never_field, .stall_rec_req, .stall_rec_done, .stall_rec_accept, .eff_out,
        .split_xn_active);
    function automatic logic [31:0] nxt(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic report_and_stop();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(logic [33:0] got, logic [33:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one bus cycle, held until waitrequest is seen low
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [33:0] e);
        expq.push_back(e);
        avs_read <= !w; avs_write <= w; avs_address <= a; avs_writedata <= d;
        do @(posedge clk_sys); while (avs_waitrequest);
        avs_read <= 0; avs_write <= 0;
        @(posedge clk_sys);
    endtask
    // answers against the oldest note; writes carry no data
    always @(posedge clk_sys)
        if (!rst && (avs_read || avs_write) && !avs_waitrequest)
            chk({avs_response, avs_write ? 32'h0 : avs_readdata}, expq.pop_front());
    // hang guard
    always @(posedge clk_sys) if (++cyc > 3000) begin fail_count++; report_and_stop(); end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        for (int i = 0; i < 3; i++) begin
            lfsr = nxt(lfsr);
            bus(0, 8'h0C + 8'(4 * i), 32'h0, {2'h0, idw[i]});
            bus(1, 8'h0C + 8'(4 * i), lfsr, 34'h0);
            bus(0, 8'h0C + 8'(4 * i), 32'h0, {2'h0, idw[i]});
        end
        bus(0, 8'h08, 32'h0, {2'h3, 32'h0});
        bus(1, 8'h30, lfsr, {2'h3, 32'h0});
        chk(34'(split_xn_active), 34'h1);
        $display("id words done");
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            bus(1, 8'h20, lfsr, 34'h0);
            bus(0, 8'h20, 32'h0, {2'h0, lfsr & 32'h1F});
            execute_never_field <= 2'(i);
            walk_device_in <= lfsr[9];
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys);
            chk(34'(eff_out), 34'({8'h0, lfsr[4:1], lfsr[9] & !lfsr[0], !i[1], i[1] == i[0]}));
            @(posedge clk_sys);
        end
        $display("stream cfg done");
        stall_rec_req <= 1;
        @(negedge clk_sys);
        chk(34'(stall_rec_accept), 34'h1);
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(34'(stall_rec_accept), 34'h0);
        @(posedge clk_sys);
        stall_rec_req <= 0;
        bus(0, 8'h24, 32'h0, {2'h0, 32'h10});
        stall_rec_done <= 1;
        @(posedge clk_sys);
        stall_rec_done <= 0;
        bus(0, 8'h24, 32'h0, {2'h0, 32'hF});
        $display("stall limit done");
        report_and_stop();
    end
endmodule
